// ===== virtual_frame_trigger.sv
// Virtual frame trigger gating for line scan acquisition
// Function
// - The line after a valid start trigger is the frame's first line.
// - Fixed length: capture exactly the configured line count, then end.
// - Variable length: trigger bounds the frame, never beyond the maximum.
// - Level or dual modes keep rolling frames while the condition holds.
// - Single edge modes grab one frame per trigger, no roll over.
// - No trigger events unless a grab is active.
// - Fixed level mode checks the level at frame end to restart.
// - Fixed mode classes each trigger as used or ignored.
// - Variable mode never issues ignored events.
// - Variable mode triggers either start or end a frame.
// - Trigger enable bit turns the external frame trigger on or off.
// - Detection code selects low, high, edge or dual-input edge.
// - Dual-input: input one starts the frame, input two ends it in variable mode and stops roll over in fixed mode.
// - Receiver code selects TTL, differential, 24 V or 12 V.
// - Camera line triggers run continuously regardless of frame state.
// - Line triggers come from the encoder or an internal generator.
//
// Decided for this implementation: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
module virtual_frame_trigger
  import vft_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone register bus
  input  wire wb_req_t     wb_req_i,
  output      wb_rsp_t     wb_rsp_o,
  // External frame trigger inputs
  input  wire logic        trig1_i,
  input  wire logic        trig2_i,
  // Camera side
  input  wire logic        enc_i,
  input  wire logic        cam_line_i,
  output      logic        cam_line_trig_o,
  // Frame control and events
  output      frame_evt_t  evt_o,
  output      logic [15:0] buf_idx_o,
  output      logic [6:0]  rx_sel_o,
  output      logic        irq_o
);

  typedef struct packed {
    acquisition_config_params_t cfg;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [15:0]      used_cnt;
    logic [15:0]      ign_cnt;
    frame_state_t     st;
    logic [15:0]      line_cnt;
    logic [15:0]      buf_idx;
    logic             t1_q;
    logic             t2_q;
    logic             dual_act;
    frame_evt_t       evt;
    logic             irq;
    wb_rsp_t          rsp;
  } core_state_t;

  core_state_t s_q;
  core_state_t s_d;

  function automatic logic is_level(input logic [6:0] det);
    return (det == DET_LOW) || (det == DET_HIGH);
  endfunction

  function automatic logic is_dual(input logic [6:0] det);
    return (det == DET_DUAL_RISE) || (det == DET_DUAL_FALL);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wdat,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = wdat[8*b +: 8];
      end
    end
    return res;
  endfunction

  logic             t1_rise;
  logic             t1_fall;
  logic             t2_rise;
  logic             t2_fall;
  logic             start_evt;
  logic             end_evt;
  logic             cond_act;
  logic             gate;
  logic             end_now;
  logic [15:0]      nxt_cnt;
  logic             hit;
  logic [31:0]      rv;
  logic [31:0]      wv;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] ev;

  always_comb begin
    s_d       = s_q;
    s_d.evt   = '0;
    t1_rise   = trig1_i & ~s_q.t1_q;
    t1_fall   = ~trig1_i & s_q.t1_q;
    t2_rise   = trig2_i & ~s_q.t2_q;
    t2_fall   = ~trig2_i & s_q.t2_q;
    start_evt = 1'b0;
    end_evt   = 1'b0;
    cond_act  = 1'b0;
    end_now   = 1'b0;
    gate      = s_q.cfg.trig_en & s_q.cfg.grab;
    nxt_cnt   = s_q.line_cnt + 16'h0001;
    hit       = wb_req_i.cyc & wb_req_i.stb & ~s_q.rsp.ack;
    rv        = '0;
    clr       = '0;
    s_d.t1_q  = trig1_i;
    s_d.t2_q  = trig2_i;

    // Register read-back
    if (wb_req_i.adr == REG_CTRL) begin
      rv[CTRL_TRIG_EN_BIT] = s_q.cfg.trig_en;
      rv[CTRL_GRAB_BIT]    = s_q.cfg.grab;
      rv[CTRL_VAR_BIT]     = s_q.cfg.var_mode;
      rv[CTRL_SRC_INT_BIT] = s_q.cfg.src_int;
    end else if (wb_req_i.adr == REG_DETECT) begin
      rv[6:0] = s_q.cfg.detect;
    end else if (wb_req_i.adr == REG_RXSEL) begin
      rv[6:0] = s_q.cfg.rx_sel;
    end else if (wb_req_i.adr == REG_MAXLINES) begin
      rv[15:0] = s_q.cfg.max_lines;
    end else if (wb_req_i.adr == REG_LINEPER) begin
      rv[15:0] = s_q.cfg.line_period;
    end else if (wb_req_i.adr == REG_STATUS) begin
      rv[STAT_CNT_LSB +: 16] = s_q.line_cnt;
      rv[STAT_ST_LSB +: 2]   = s_q.st;
      rv[STAT_DUAL_BIT]      = s_q.dual_act;
      rv[STAT_T1_BIT]        = s_q.t1_q;
      rv[STAT_T2_BIT]        = s_q.t2_q;
    end else if (wb_req_i.adr == REG_IRQ_STAT) begin
      rv[IRQ_W-1:0] = s_q.irq_stat;
    end else if (wb_req_i.adr == REG_IRQ_MASK) begin
      rv[IRQ_W-1:0] = s_q.irq_mask;
    end else if (wb_req_i.adr == REG_EVCNT) begin
      rv = {s_q.ign_cnt, s_q.used_cnt};
    end else if (wb_req_i.adr == REG_BUFIDX) begin
      rv[15:0] = s_q.buf_idx;
    end
    wv = merge(rv, wb_req_i.dat, wb_req_i.sel);

    // One-cycle answer; unmapped reads return zero, unmapped writes drop
    s_d.rsp.ack = hit;
    s_d.rsp.dat = (hit && !wb_req_i.we) ? rv : '0;
    if (hit && wb_req_i.we) begin
      if (wb_req_i.adr == REG_CTRL) begin
        s_d.cfg.trig_en  = wv[CTRL_TRIG_EN_BIT];
        s_d.cfg.grab     = wv[CTRL_GRAB_BIT];
        s_d.cfg.var_mode = wv[CTRL_VAR_BIT];
        s_d.cfg.src_int  = wv[CTRL_SRC_INT_BIT];
      end else if (wb_req_i.adr == REG_DETECT) begin
        s_d.cfg.detect = wv[6:0];
      end else if (wb_req_i.adr == REG_RXSEL) begin
        s_d.cfg.rx_sel = wv[6:0];
      end else if (wb_req_i.adr == REG_MAXLINES) begin
        s_d.cfg.max_lines = wv[15:0];
      end else if (wb_req_i.adr == REG_LINEPER) begin
        s_d.cfg.line_period = wv[15:0];
      end else if (wb_req_i.adr == REG_IRQ_STAT) begin
        clr = wb_req_i.dat[IRQ_W-1:0] & {IRQ_W{wb_req_i.sel[0]}};
      end else if (wb_req_i.adr == REG_IRQ_MASK) begin
        s_d.irq_mask = wv[IRQ_W-1:0];
      end
    end

    // Trigger condition decode; input two only counts in dual modes
    case (s_q.cfg.detect)
      DET_LOW: begin
        start_evt = t1_fall;
        end_evt   = t1_rise;
        cond_act  = ~trig1_i;
      end
      DET_HIGH: begin
        start_evt = t1_rise;
        end_evt   = t1_fall;
        cond_act  = trig1_i;
      end
      DET_RISE: begin
        start_evt = t1_rise;
        end_evt   = t1_rise;
      end
      DET_FALL: begin
        start_evt = t1_fall;
        end_evt   = t1_fall;
      end
      DET_DUAL_RISE: begin
        start_evt = t1_rise;
        end_evt   = t2_rise;
      end
      DET_DUAL_FALL: begin
        start_evt = t1_fall;
        end_evt   = t2_fall;
      end
      default: begin
        start_evt = 1'b0;
      end
    endcase

    // Dual window: open from an input one edge to an input two edge
    if (!is_dual(s_q.cfg.detect)) begin
      s_d.dual_act = 1'b0;
    end else if (start_evt) begin
      s_d.dual_act = 1'b1;
    end else if (end_evt) begin
      s_d.dual_act = 1'b0;
    end
    if (is_dual(s_q.cfg.detect)) begin
      cond_act = s_d.dual_act;
    end

    case (s_q.st)
      ST_IDLE: begin
        if (gate && start_evt) begin
          s_d.evt.trigger_used_event = 1'b1;
          s_d.evt.frame_start        = 1'b1;
          s_d.line_cnt               = '0;
          s_d.st                     = ST_ARM;
        end
      end
      ST_ARM, ST_CAP: begin
        if (gate && start_evt && !s_q.cfg.var_mode) begin
          s_d.evt.trigger_ignored_event = 1'b1;
        end
        if (gate && end_evt && s_q.cfg.var_mode) begin
          s_d.evt.trigger_used_event = 1'b1;
          end_now                    = 1'b1;
        end else if (cam_line_i) begin
          s_d.evt.line_store = 1'b1;
          s_d.line_cnt       = nxt_cnt;
          s_d.st             = ST_CAP;
          if (nxt_cnt >= s_q.cfg.max_lines) begin
            end_now = 1'b1;
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // Roll over only for level and dual modes, never for single edges
    if (end_now) begin
      s_d.evt.frame_end = 1'b1;
      s_d.buf_idx       = s_q.buf_idx + 16'h0001;
      if ((is_level(s_q.cfg.detect) || is_dual(s_q.cfg.detect))
          && cond_act && gate) begin
        s_d.evt.frame_start = 1'b1;
        s_d.line_cnt        = '0;
        s_d.st              = ST_ARM;
      end else begin
        s_d.st = ST_IDLE;
      end
    end

    if (s_d.evt.trigger_used_event) begin
      s_d.used_cnt = s_q.used_cnt + 16'h0001;
    end
    if (s_d.evt.trigger_ignored_event) begin
      s_d.ign_cnt = s_q.ign_cnt + 16'h0001;
    end

    // New events win over a clear in the same cycle
    ev                     = '0;
    ev[IRQ_USED_BIT]       = s_d.evt.trigger_used_event;
    ev[IRQ_IGN_BIT]        = s_d.evt.trigger_ignored_event;
    ev[IRQ_SOF_BIT]        = s_d.evt.frame_start;
    ev[IRQ_EOF_BIT]        = s_d.evt.frame_end;
    s_d.irq_stat           = (s_q.irq_stat & ~clr) | ev;
    s_d.irq                = |(s_d.irq_stat & s_d.irq_mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q                 <= '0;
      s_q.cfg.detect      <= DETECT_RST;
      s_q.cfg.rx_sel      <= RXSEL_RST;
      s_q.cfg.max_lines   <= MAXLINES_RST;
      s_q.cfg.line_period <= LINEPER_RST;
    end else begin
      s_q <= s_d;
    end
  end

  line_trigger_gen u_line_trig (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .src_int_i   (s_q.cfg.src_int),
    .period_i    (s_q.cfg.line_period),
    .enc_i       (enc_i),
    .line_trig_o (cam_line_trig_o)
  );

  assign wb_rsp_o  = s_q.rsp;
  assign evt_o     = s_q.evt;
  assign buf_idx_o = s_q.buf_idx;
  assign rx_sel_o  = s_q.cfg.rx_sel;
  assign irq_o     = s_q.irq;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_no_grab;
    !s_q.cfg.grab |=> !(evt_o.trigger_used_event
                        || evt_o.trigger_ignored_event);
  endproperty
  a_no_grab: assert property (p_no_grab)
    else $error("trigger event while not grabbing");

  property p_trig_off;
    !s_q.cfg.trig_en |=> !evt_o.frame_start;
  endproperty
  a_trig_off: assert property (p_trig_off)
    else $error("frame started with trigger disabled");

  property p_var_no_ign;
    s_q.cfg.var_mode |=> !evt_o.trigger_ignored_event;
  endproperty
  a_var_no_ign: assert property (p_var_no_ign)
    else $error("ignored event in variable mode");

  property p_fixed_used;
    (s_q.st == ST_IDLE && gate && start_evt)
      |=> evt_o.trigger_used_event && evt_o.frame_start
          && s_q.st == ST_ARM;
  endproperty
  a_fixed_used: assert property (p_fixed_used)
    else $error("start trigger not used");

  property p_first_line;
    (s_q.st == ST_ARM && cam_line_i && !s_q.cfg.var_mode)
      |=> evt_o.line_store && s_q.line_cnt == 16'h0001;
  endproperty
  a_first_line: assert property (p_first_line)
    else $error("first line after trigger not stored");

  property p_fixed_len;
    (s_q.st == ST_CAP && !s_q.cfg.var_mode && cam_line_i
      && nxt_cnt == s_q.cfg.max_lines) |=> evt_o.frame_end;
  endproperty
  a_fixed_len: assert property (p_fixed_len)
    else $error("frame did not end at line count");

  property p_max_bound;
    (s_q.st == ST_CAP) |-> (s_q.line_cnt < s_q.cfg.max_lines);
  endproperty
  a_max_bound: assert property (p_max_bound)
    else $error("line count reached maximum inside frame");

  property p_cnt_clear;
    evt_o.frame_start |-> s_q.line_cnt == 16'h0000;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("line counter not cleared at frame start");

  property p_edge_once;
    (evt_o.frame_end && !is_level(s_q.cfg.detect)
      && !is_dual(s_q.cfg.detect)) |-> s_q.st == ST_IDLE;
  endproperty
  a_edge_once: assert property (p_edge_once)
    else $error("edge mode rolled over");

  property p_var_end;
    (s_q.cfg.var_mode && gate && end_evt && s_q.st != ST_IDLE)
      |=> evt_o.frame_end && evt_o.trigger_used_event;
  endproperty
  a_var_end: assert property (p_var_end)
    else $error("variable mode end trigger not used");

endmodule

// ===== vft_pkg.sv
// Shared constants, codes and carrier types of the virtual frame trigger
package vft_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_DETECT   = 8'h04;
  localparam logic [7:0] REG_RXSEL    = 8'h08;
  localparam logic [7:0] REG_MAXLINES = 8'h0C;
  localparam logic [7:0] REG_LINEPER  = 8'h10;
  localparam logic [7:0] REG_STATUS   = 8'h14;
  localparam logic [7:0] REG_IRQ_STAT = 8'h18;
  localparam logic [7:0] REG_IRQ_MASK = 8'h1C;
  localparam logic [7:0] REG_EVCNT    = 8'h20;
  localparam logic [7:0] REG_BUFIDX   = 8'h24;

  // Control register bit positions
  localparam int CTRL_TRIG_EN_BIT = 0;
  localparam int CTRL_GRAB_BIT    = 1;
  localparam int CTRL_VAR_BIT     = 2;
  localparam int CTRL_SRC_INT_BIT = 3;

  // Status register field positions
  localparam int STAT_CNT_LSB  = 0;
  localparam int STAT_ST_LSB   = 16;
  localparam int STAT_DUAL_BIT = 18;
  localparam int STAT_T1_BIT   = 19;
  localparam int STAT_T2_BIT   = 20;

  // Interrupt status and mask bit positions
  localparam int IRQ_USED_BIT = 0;
  localparam int IRQ_IGN_BIT  = 1;
  localparam int IRQ_SOF_BIT  = 2;
  localparam int IRQ_EOF_BIT  = 3;
  localparam int IRQ_W        = 4;

  // Trigger detection codes
  localparam logic [6:0] DET_LOW       = 7'h01;
  localparam logic [6:0] DET_HIGH      = 7'h02;
  localparam logic [6:0] DET_RISE      = 7'h04;
  localparam logic [6:0] DET_FALL      = 7'h08;
  localparam logic [6:0] DET_DUAL_RISE = 7'h20;
  localparam logic [6:0] DET_DUAL_FALL = 7'h40;

  // Trigger receiver codes
  localparam logic [6:0] RX_TTL  = 7'h01;
  localparam logic [6:0] RX_DIFF = 7'h02;
  localparam logic [6:0] RX_24V  = 7'h08;
  localparam logic [6:0] RX_12V  = 7'h40;

  // Reset values
  localparam logic [6:0]  DETECT_RST   = DET_RISE;
  localparam logic [6:0]  RXSEL_RST    = RX_TTL;
  localparam logic [15:0] MAXLINES_RST = 16'h000A;
  localparam logic [15:0] LINEPER_RST  = 16'h0100;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM  = 2'b01,
    ST_CAP  = 2'b11
  } frame_state_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic line_store;
    logic frame_start;
    logic frame_end;
    logic trigger_used_event;
    logic trigger_ignored_event;
  } frame_evt_t;

  typedef struct packed {
    logic        trig_en;
    logic        grab;
    logic        var_mode;
    logic        src_int;
    logic [6:0]  detect;
    logic [6:0]  rx_sel;
    logic [15:0] max_lines;
    logic [15:0] line_period;
  } acquisition_config_params_t;

endpackage

// ===== line_trigger_gen.sv
// Continuous camera line trigger from shaft encoder or internal timer
`timescale 1ns/1ps
module line_trigger_gen
  import vft_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Source selection
  input  wire logic        src_int_i,
  input  wire logic [15:0] period_i,
  input  wire logic        enc_i,
  // Camera line trigger
  output      logic        line_trig_o
);

  typedef struct packed {
    logic        enc_q;
    logic [15:0] cnt;
    logic        trig;
  } gen_state_t;

  gen_state_t s_q;
  gen_state_t s_d;

  // Never gated by frame state: the camera must run free between frames
  always_comb begin
    s_d       = s_q;
    s_d.enc_q = enc_i;
    s_d.trig  = 1'b0;
    if (src_int_i) begin
      if (s_q.cnt + 16'h0001 >= period_i) begin
        s_d.cnt  = '0;
        s_d.trig = 1'b1;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end else begin
      s_d.cnt  = '0;
      s_d.trig = enc_i & ~s_q.enc_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign line_trig_o = s_q.trig;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_enc_trig;
    (!src_int_i && enc_i && !s_q.enc_q) |=> line_trig_o;
  endproperty
  a_enc_trig: assert property (p_enc_trig)
    else $error("encoder edge gave no line trigger");

  // Judged only while source and period hold across the whole gap
  property p_int_period;
    (src_int_i && period_i == 16'h0004 && line_trig_o)
      ##1 (src_int_i && period_i == 16'h0004) [*3]
      |=> line_trig_o && !$past(line_trig_o)
          && !$past(line_trig_o, 2) && !$past(line_trig_o, 3);
  endproperty
  a_int_period: assert property (p_int_period)
    else $error("internal line trigger period wrong");

endmodule

// ===== trig_cam_model.sv
// Trigger source and line scan camera model at the far side
`timescale 1ns/1ps
module trig_cam_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Levels and encoder motion asked for by the bench
  input  wire logic t1_i,
  input  wire logic t2_i,
  input  wire logic enc_run_i,
  // Line trigger from the grabber
  input  wire logic line_trig_i,
  // Far side outputs
  output      logic trig1_o,
  output      logic trig2_o,
  output      logic enc_o,
  output      logic cam_line_o
);
  logic [1:0] dly_q;
  logic [2:0] enc_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig1_o <= 1'b0;
      trig2_o <= 1'b0;
      dly_q   <= 2'h0;
      enc_q   <= 3'h0;
    end else begin
      trig1_o <= t1_i;
      trig2_o <= t2_i;
      // Camera sends a video line only in answer to a line trigger
      dly_q   <= {dly_q[0], line_trig_i};
      enc_q   <= enc_run_i ? enc_q + 3'h1 : enc_q;
    end
  end
  assign cam_line_o = dly_q[1];
  // Encoder edge every eight cycles while the web moves
  assign enc_o      = enc_q[2];
endmodule

// ===== virtual_frame_trigger_tb.sv
// Self-checking testbench of the virtual frame trigger
`timescale 1ns/1ps
module virtual_frame_trigger_tb;
  import vft_pkg::*;
  localparam logic [31:0] C_EN = 32'h0000_0009;
  localparam logic [31:0] C_GR = 32'h0000_000B;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  wb_req_t     wb_req = '0;
  wb_rsp_t     wb_rsp;
  logic        t1 = 1'b0;
  logic        t2 = 1'b0;
  logic        enc_run = 1'b0;
  logic        trig1, trig2, enc, cam_line, line_trig, irq;
  frame_evt_t  evt;
  logic [15:0] buf_idx;
  logic [6:0]  rx_sel;
  int          err_count = 0;
  int          n_compared = 0;
  int          n_fs = 0, n_fe = 0, n_ls = 0, n_u = 0, n_i = 0, n_lt = 0;
  int          s_fs, s_fe, s_ls, s_u, s_i;

  always #2 clk_i = ~clk_i;

  virtual_frame_trigger dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_rsp_o(wb_rsp),
    .trig1_i(trig1), .trig2_i(trig2), .enc_i(enc), .cam_line_i(cam_line),
    .cam_line_trig_o(line_trig), .evt_o(evt), .buf_idx_o(buf_idx),
    .rx_sel_o(rx_sel), .irq_o(irq));

  trig_cam_model far_u (
    .clk_i(clk_i), .rst_i(rst_i), .t1_i(t1), .t2_i(t2),
    .enc_run_i(enc_run), .line_trig_i(line_trig), .trig1_o(trig1),
    .trig2_o(trig2), .enc_o(enc), .cam_line_o(cam_line));

  always @(posedge clk_i) begin
    n_fs <= n_fs + evt.frame_start;
    n_fe <= n_fe + evt.frame_end;
    n_ls <= n_ls + evt.line_store;
    n_u  <= n_u + evt.trigger_used_event;
    n_i  <= n_i + evt.trigger_ignored_event;
    n_lt <= n_lt + line_trig;
  end

  task automatic conclude;
    if (err_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input bit ok, input string m);
    n_compared++;
    if (!ok) begin
      err_count++;
      $display("Error %0t: %s", $time, m);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Request stays put until ack is sampled, then idles one cycle;
  // no local limit, a hang is ended by the watchdog
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
    @(posedge clk_i);
    while (wb_rsp.ack !== 1'b1) begin
      @(posedge clk_i);
      n++;
    end
    chk(n == 1, "bus ack not one cycle after request");
    q = wb_rsp.dat;
    wb_req <= '0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic snap;
    s_fs = n_fs;
    s_fe = n_fe;
    s_ls = n_ls;
    s_u  = n_u;
    s_i  = n_i;
  endtask

  task automatic s_reset;
    logic [31:0] q;
    logic [6:0]  rx[4] = '{RX_TTL, RX_DIFF, RX_24V, RX_12V};
    wb(1'b0, REG_DETECT, 32'h0, q);
    chk(q[6:0] === DETECT_RST, "detect reset value");
    wb(1'b0, REG_MAXLINES, 32'h0, q);
    chk(q[15:0] === MAXLINES_RST, "max lines reset value");
    chk(rx_sel === RX_TTL, "receiver reset value");
    wb(1'b0, 8'hFC, 32'h0, q);
    chk(q === 32'h0000_0000, "unmapped read not zero");
    for (int k = 0; k < 4; k++) begin
      wr(REG_RXSEL, {25'h0, rx[k]});
      chk(rx_sel === rx[k], "receiver code");
    end
  endtask

  // Line triggers run with grab off, from timer then from encoder
  task automatic s_lines;
    int a;
    wr(REG_LINEPER, 32'h0000_0004);
    wr(REG_CTRL, 32'h0000_0008);
    a = n_lt;
    cyc(40);
    chk(n_lt - a == 10, "internal line trigger rate");
    wr(REG_CTRL, 32'h0000_0000);
    enc_run <= 1'b1;
    a = n_lt;
    cyc(80);
    chk(n_lt - a inside {[9:11]}, "encoder line triggers");
    enc_run <= 1'b0;
  endtask

  task automatic s_fixed;
    logic [31:0] q;
    logic [15:0] b;
    wr(REG_MAXLINES, 32'h0000_0003);
    wr(REG_CTRL, C_EN);
    snap;
    t1 <= 1'b1;
    cyc(30);
    t1 <= 1'b0;
    wr(REG_CTRL, 32'h0000_000A);
    t1 <= 1'b1;
    cyc(30);
    chk(n_fs == s_fs && n_u == s_u, "event while gated");
    t1 <= 1'b0;
    wr(REG_CTRL, C_GR);
    b = buf_idx;
    snap;
    t1 <= 1'b1;
    cyc(3);
    t1 <= 1'b0;
    cyc(2);
    t1 <= 1'b1;
    cyc(60);
    chk(n_fs - s_fs == 1 && n_fe - s_fe == 1, "one frame");
    chk(n_ls - s_ls == 3, "fixed line count");
    chk(n_u - s_u == 1 && n_i - s_i == 1, "used/ignored");
    chk(buf_idx === b + 16'h0001, "buffer index step");
    wb(1'b0, REG_EVCNT, 32'h0, q);
    chk(q === 32'h0001_0001, "event counts");
    wb(1'b0, REG_BUFIDX, 32'h0, q);
    chk(q[15:0] === b + 16'h0001, "buffer index read");
    wb(1'b0, REG_STATUS, 32'h0, q);
    chk(q[20:0] === 21'h08_0003, "status after frame");
    t1 <= 1'b0;
  endtask

  // Per code: {roll over, dual, idle level, code}
  task automatic s_modes;
    logic [9:0] m[6] = '{{3'b101, DET_LOW}, {3'b100, DET_HIGH},
                         {3'b000, DET_RISE}, {3'b001, DET_FALL},
                         {3'b110, DET_DUAL_RISE}, {3'b111, DET_DUAL_FALL}};
    logic [9:0] e;
    wr(REG_MAXLINES, 32'h0000_0002);
    for (int k = 0; k < 6; k++) begin
      e = m[k];
      wr(REG_CTRL, C_EN);
      wr(REG_DETECT, {25'h0, e[6:0]});
      t1 <= e[7];
      t2 <= e[7];
      cyc(4);
      wr(REG_CTRL, C_GR);
      snap;
      t2 <= ~e[7];
      cyc(20);
      chk(e[8] || n_fs == s_fs, "input two started a frame");
      t2 <= e[7];
      cyc(2);
      snap;
      t1 <= ~e[7];
      cyc(40);
      if (e[8])
        t2 <= ~e[7];
      else
        t1 <= e[7];
      cyc(30);
      if (e[9])
        chk(n_fs - s_fs >= 2, "no roll over");
      else
        chk(n_fs - s_fs == 1, "edge mode rolled");
      chk(n_fs == n_fe, "frame left open");
    end
  endtask

  task automatic s_var;
    wr(REG_CTRL, 32'h0000_000D);
    wr(REG_MAXLINES, 32'h0000_000A);
    wr(REG_DETECT, {25'h0, DET_DUAL_RISE});
    t1 <= 1'b0;
    t2 <= 1'b0;
    cyc(4);
    wr(REG_CTRL, 32'h0000_000F);
    snap;
    t1 <= 1'b1;
    cyc(14);
    t2 <= 1'b1;
    cyc(30);
    chk(n_fs - s_fs == 1 && n_fe - s_fe == 1, "dual frame");
    chk(n_ls - s_ls inside {[1:9]}, "variable length");
    chk(n_i == s_i, "ignored in variable mode");
    chk(n_u - s_u == 2, "start and end used");
    wr(REG_CTRL, C_EN);
    t1 <= 1'b0;
    t2 <= 1'b0;
  endtask

  task automatic s_irq;
    wr(REG_DETECT, {25'h0, DET_RISE});
    wr(REG_IRQ_MASK, 32'h0000_0001);
    wr(REG_IRQ_STAT, 32'h0000_000F);
    cyc(2);
    chk(irq === 1'b0, "irq after clear");
    wr(REG_CTRL, C_GR);
    t1 <= 1'b1;
    cyc(30);
    chk(irq === 1'b1, "irq on used trigger");
    wr(REG_IRQ_MASK, 32'h0000_0000);
    cyc(2);
    chk(irq === 1'b0, "irq masked");
    wr(REG_IRQ_MASK, 32'h0000_0001);
    wr(REG_IRQ_STAT, 32'h0000_0001);
    cyc(2);
    chk(irq === 1'b0, "irq cleared");
    t1 <= 1'b0;
  endtask

  // Whole run is about a thousand cycles
  initial begin
    #100000;
    err_count++;
    conclude;
  end

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    s_reset;
    s_lines;
    s_fixed;
    s_modes;
    s_var;
    s_irq;
    conclude;
  end
endmodule
